// >>> sqf_phy_model.sv
`timescale 1ns/1ps
module sqf_phy_model (
   output logic recovered_symbol_clock,
   output logic [2:0] line_symbol
);
   initial begin
      recovered_symbol_clock = 1'b0;
      line_symbol = sqf_pkg::SYM_SILENCE;
   end
   // symbol changes on the falling edge, 400 ns period
   // calls start on a system clock edge, so every change is non-blocking to avoid a race
   task automatic send(input logic [2:0] s);
      line_symbol <= s;
      #200 recovered_symbol_clock <= 1'b1;
      #200 recovered_symbol_clock <= 1'b0;
   endtask
   // clock stands still between bursts; the stale symbol is inverted so it is never trusted
   task automatic rest();
      #1 line_symbol <= ~line_symbol;
   endtask
endmodule // sqf_phy_model

// >>> sqf_pkg.sv
package sqf_pkg;

   // six-valued line alphabet, one code per recovered symbol clock
   typedef enum logic [2:0] {
      SYM_ZERO,
      SYM_ONE,
      SYM_NON_DATA,
      SYM_PAD_IDLE,
      SYM_SILENCE,
      SYM_BAD_SIGNAL
   } sqf_sym_e;

   typedef enum logic [1:0] {
      RX_WAIT,
      RX_DATA,
      RX_EXIT
   } sqf_rx_e;

   typedef struct packed {
      logic sd;
      logic ed;
      logic byte_strobe;
      logic err;
   } sqf_event_s;

   typedef struct packed {
      logic bus_quiet;
      logic noise_burst;
      logic rx_protocol_frame;
      logic rx_data_frame;
   } sqf_flags_s;

   localparam int OCTET_SYMBOLS = 8;
   localparam int SYM_W = 3;
   localparam int HIST_W = OCTET_SYMBOLS * SYM_W;
   localparam int SIL_COUNT = 8;
   localparam int ACT_COUNT = 3;
   localparam int LAST_BIT = OCTET_SYMBOLS - 1;
   localparam int EXIT_LAST = OCTET_SYMBOLS - 2;

   // delimiters, oldest symbol leftmost
   localparam logic [HIST_W-1:0] SD_PATTERN = {SYM_NON_DATA, SYM_NON_DATA, SYM_ZERO,
      SYM_NON_DATA, SYM_NON_DATA, SYM_ZERO, SYM_ZERO, SYM_ZERO};
   localparam logic [HIST_W-7:0] ED_HEAD = {SYM_NON_DATA, SYM_NON_DATA, SYM_ONE,
      SYM_NON_DATA, SYM_NON_DATA, SYM_ONE};

   localparam logic [31:0] CRC_POLY = 32'h04c11db7;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [31:0] CRC_RESIDUE = 32'hc704dd7b;

   localparam int FC_TYPE_HI = 7;
   localparam int FC_TYPE_LO = 6;
   localparam logic [1:0] FC_TYPE_CONTROL = 2'h0;
   localparam logic [1:0] FC_TYPE_RESERVED = 2'h3;
   localparam int FC_OCTETS = 1;
   localparam int FCS_OCTETS = 4;

endpackage

// >>> sqf_receive_framer.sv
`timescale 1ns/1ps
// Behaviour
// - bus quiet never rises before frame flag
// - delimiters detected regardless of receive context
// - end delimiter detect returned to physical layer
// - start delimiter reinitialises detector, fixes alignment
// - byte strobe every eight data symbols
// - pad, silence, bad symbol: error, stop
// - non-data off octet boundary: error, stop
// - boundary non-data without delimiter: error, stop
// - start delimiter: reinit, error if mid-frame
// - end delimiter ends reception without error
// - check sum reset by start, shifts data
// - deserializer output valid only at reports
// - noise burst on quiet rise without frame
// - buffer octets, check control octet, count
// - valid needs good check sum, whole octets
// - six symbols; zero, one carry data
// - octet equals eight line symbols
// - symbol period equals inverse data rate
// - silence after eight, activity after three
// - frame flags set here, cleared by others
// - noise burst set here, cleared by others
// - buffer holds first BUF_DEPTH octets of each frame
module sqf_receive_framer #(
   parameter int ADDR_OCTETS = 6,
   parameter int MAX_OCTETS = 8191,
   parameter int BUF_DEPTH = 32
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic recovered_symbol_clock,
   input wire logic [2:0] line_symbol,
   input wire logic clr_protocol_frame,
   input wire logic clr_data_frame,
   input wire logic clr_noise_burst,
   output logic end_delim_detect,
   output sqf_pkg::sqf_event_s events,
   output logic [7:0] rx_byte,
   output sqf_pkg::sqf_flags_s flags,
   output logic [$clog2(MAX_OCTETS+2)-1:0] frame_length,
   output logic [BUF_DEPTH*8-1:0] frame_buffer
);

   localparam int LEN_W = $clog2(MAX_OCTETS + 2);
   localparam int BUF_IW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
   localparam int MIN_OCTETS = sqf_pkg::FC_OCTETS + 2 * ADDR_OCTETS + sqf_pkg::FCS_OCTETS;

   if (ADDR_OCTETS != 2 && ADDR_OCTETS != 6) begin : g_bad_addr
      $error("address length must be 2 or 6 octets");
   end
   if (MAX_OCTETS < MIN_OCTETS || BUF_DEPTH < MIN_OCTETS) begin : g_bad_size
      $error("maximum length and buffer depth must hold a minimal frame");
   end

   function automatic logic is_sd(input logic [sqf_pkg::HIST_W-1:0] h);
      return h == sqf_pkg::SD_PATTERN;
   endfunction

   function automatic logic is_data(input logic [2:0] s);
      return s == sqf_pkg::SYM_ZERO || s == sqf_pkg::SYM_ONE;
   endfunction

   function automatic logic is_ed(input logic [sqf_pkg::HIST_W-1:0] h);
      return h[sqf_pkg::HIST_W-1:6] == sqf_pkg::ED_HEAD && is_data(h[5:3]) && is_data(h[2:0]);
   endfunction

   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
      return {c[30:0], 1'b0} ^ ((c[31] ^ b) ? sqf_pkg::CRC_POLY : 32'h00000000);
   endfunction

   // reset release
   logic rst_s1;
   logic rst_s2;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end

   // link sampling; the phy is expected to change symbols near its falling edge,
   // so clock and data through equal-length synchronisers stay aligned
   logic clk_s1;
   logic clk_s2;
   logic clk_s3;
   logic [2:0] sym_s1;
   logic [2:0] sym_s2;
   logic next_clk_s1;
   logic next_clk_s2;
   logic next_clk_s3;
   logic [2:0] next_sym_s1;
   logic [2:0] next_sym_s2;
   logic step;

   always_comb begin
      next_clk_s1 = recovered_symbol_clock;
      next_clk_s2 = clk_s1;
      next_clk_s3 = clk_s2;
      next_sym_s1 = line_symbol;
      next_sym_s2 = sym_s1;
      step = clk_s2 & ~clk_s3; // one symbol per rising edge
   end

   always_ff @(posedge clock or negedge rst_s2) begin
      if (!rst_s2) begin
         clk_s1 <= 1'b0;
         clk_s2 <= 1'b0;
         clk_s3 <= 1'b0;
         sym_s1 <= sqf_pkg::SYM_SILENCE;
         sym_s2 <= sqf_pkg::SYM_SILENCE;
      end else begin
         clk_s1 <= next_clk_s1;
         clk_s2 <= next_clk_s2;
         clk_s3 <= next_clk_s3;
         sym_s1 <= next_sym_s1;
         sym_s2 <= next_sym_s2;
      end
   end

   // receive core
   logic [sqf_pkg::HIST_W-1:0] hist;
   sqf_pkg::sqf_rx_e rx_state;
   logic [2:0] bit_cnt;
   logic [2:0] exit_cnt;
   logic [7:0] deser;
   logic [31:0] crc;
   logic crc_on;
   logic [LEN_W-1:0] octet_cnt;
   logic [7:0] fbuf [BUF_DEPTH];
   logic [3:0] sil_cnt;
   logic [1:0] act_cnt;
   logic valid_seen;

   logic [sqf_pkg::HIST_W-1:0] next_hist;
   sqf_pkg::sqf_rx_e next_rx_state;
   logic [2:0] next_bit_cnt;
   logic [2:0] next_exit_cnt;
   logic [7:0] next_deser;
   logic [31:0] next_crc;
   logic next_crc_on;
   logic [LEN_W-1:0] next_octet_cnt;
   logic [7:0] next_fbuf [BUF_DEPTH];
   logic [3:0] next_sil_cnt;
   logic [1:0] next_act_cnt;
   logic next_valid_seen;
   logic next_end_delim_detect;
   sqf_pkg::sqf_event_s next_events;
   logic [7:0] next_rx_byte;
   sqf_pkg::sqf_flags_s next_flags;
   logic [LEN_W-1:0] next_frame_length;

   always_comb begin
      logic [2:0] s;
      logic sd_hit;
      logic ed_hit;
      logic data_sym;
      logic frame_ok;
      logic [1:0] fc_type;
      s = sym_s2;
      next_hist = hist;
      next_rx_state = rx_state;
      next_bit_cnt = bit_cnt;
      next_exit_cnt = exit_cnt;
      next_deser = deser;
      next_crc = crc;
      next_crc_on = crc_on;
      next_octet_cnt = octet_cnt;
      next_fbuf = fbuf;
      next_sil_cnt = sil_cnt;
      next_act_cnt = act_cnt;
      next_valid_seen = valid_seen;
      next_end_delim_detect = 1'b0;
      next_events = '0;
      next_rx_byte = rx_byte;
      next_frame_length = frame_length;
      next_flags = flags;
      // clears first so that a set in the same cycle wins
      next_flags.rx_protocol_frame = flags.rx_protocol_frame & ~clr_protocol_frame;
      next_flags.rx_data_frame = flags.rx_data_frame & ~clr_data_frame;
      next_flags.noise_burst = flags.noise_burst & ~clr_noise_burst;
      sd_hit = 1'b0;
      ed_hit = 1'b0;
      data_sym = is_data(s);
      frame_ok = 1'b0;
      fc_type = fbuf[0][sqf_pkg::FC_TYPE_HI:sqf_pkg::FC_TYPE_LO];
      if (step) begin
         next_hist = {hist[sqf_pkg::HIST_W-sqf_pkg::SYM_W-1:0], s};
         sd_hit = is_sd(next_hist);
         ed_hit = is_ed(next_hist);
         next_end_delim_detect = ed_hit;
         // hysteresis on the quiet flag
         if (s == sqf_pkg::SYM_SILENCE) begin
            next_act_cnt = 2'h0;
            if (sil_cnt < 4'(sqf_pkg::SIL_COUNT)) begin
               next_sil_cnt = sil_cnt + 4'h1;
            end
         end else begin
            next_sil_cnt = 4'h0;
            if (act_cnt < 2'(sqf_pkg::ACT_COUNT)) begin
               next_act_cnt = act_cnt + 2'h1;
            end
         end
         if (next_sil_cnt == 4'(sqf_pkg::SIL_COUNT) && !flags.bus_quiet) begin
            next_flags.bus_quiet = 1'b1;
            if (!valid_seen) begin
               next_flags.noise_burst = 1'b1;
            end
         end else if (next_act_cnt == 2'(sqf_pkg::ACT_COUNT) && flags.bus_quiet) begin
            next_flags.bus_quiet = 1'b0;
            next_valid_seen = 1'b0;
         end
         // check sum runs over data symbols until the first non-data one
         if (crc_on) begin
            if (data_sym) begin
               next_crc = crc_step(crc, s[0]);
            end else begin
               next_crc_on = 1'b0;
            end
         end
         if (sd_hit) begin
            // delimiter bit values are not passed on
            next_events.sd = 1'b1;
            next_events.err = (rx_state == sqf_pkg::RX_EXIT);
            next_rx_state = sqf_pkg::RX_DATA;
            next_bit_cnt = 3'h0;
            next_octet_cnt = '0;
            next_crc = sqf_pkg::CRC_INIT;
            next_crc_on = 1'b1;
         end else if (ed_hit && rx_state == sqf_pkg::RX_EXIT) begin
            next_events.ed = 1'b1;
            next_rx_state = sqf_pkg::RX_WAIT;
            next_frame_length = octet_cnt;
            // exit is only reached on an octet boundary, so every octet was whole
            frame_ok = (crc == sqf_pkg::CRC_RESIDUE) && (octet_cnt >= LEN_W'(MIN_OCTETS))
               && (octet_cnt <= LEN_W'(MAX_OCTETS)) && (fc_type != sqf_pkg::FC_TYPE_RESERVED);
            if (frame_ok) begin
               // flag set here while quiet can only rise on a later symbol
               next_valid_seen = 1'b1;
               if (fc_type == sqf_pkg::FC_TYPE_CONTROL) begin
                  next_flags.rx_protocol_frame = 1'b1;
               end else begin
                  next_flags.rx_data_frame = 1'b1;
               end
            end
         end else begin
            case (rx_state)
               sqf_pkg::RX_DATA: begin
                  if (data_sym) begin
                     next_deser = {deser[6:0], s[0]};
                     next_bit_cnt = bit_cnt + 3'h1;
                     if (bit_cnt == 3'(sqf_pkg::LAST_BIT)) begin
                        next_events.byte_strobe = 1'b1;
                        next_rx_byte = next_deser;
                        if (octet_cnt < LEN_W'(BUF_DEPTH)) begin
                           next_fbuf[BUF_IW'(octet_cnt)] = next_deser;
                        end
                        if (octet_cnt <= LEN_W'(MAX_OCTETS)) begin
                           next_octet_cnt = octet_cnt + LEN_W'(1);
                        end
                     end
                  end else if (s == sqf_pkg::SYM_NON_DATA && bit_cnt == 3'h0) begin
                     next_rx_state = sqf_pkg::RX_EXIT;
                     next_exit_cnt = 3'h0;
                  end else begin
                     next_events.err = 1'b1;
                     next_rx_state = sqf_pkg::RX_WAIT;
                  end
               end
               sqf_pkg::RX_EXIT: begin
                  next_exit_cnt = exit_cnt + 3'h1;
                  if (!data_sym && s != sqf_pkg::SYM_NON_DATA) begin
                     next_events.err = 1'b1;
                     next_rx_state = sqf_pkg::RX_WAIT;
                  end else if (exit_cnt == 3'(sqf_pkg::EXIT_LAST)) begin
                     next_events.err = 1'b1;
                     next_rx_state = sqf_pkg::RX_WAIT;
                  end
               end
               sqf_pkg::RX_WAIT: begin
                  next_rx_state = sqf_pkg::RX_WAIT;
               end
               default: begin
                  next_rx_state = sqf_pkg::RX_WAIT;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clock or negedge rst_s2) begin
      if (!rst_s2) begin
         hist <= '0;
         rx_state <= sqf_pkg::RX_WAIT;
         bit_cnt <= 3'h0;
         exit_cnt <= 3'h0;
         deser <= 8'h00;
         crc <= sqf_pkg::CRC_INIT;
         crc_on <= 1'b0;
         octet_cnt <= '0;
         fbuf <= '{default: 8'h00};
         sil_cnt <= 4'h0;
         act_cnt <= 2'h0;
         valid_seen <= 1'b0;
         end_delim_detect <= 1'b0;
         events <= '0;
         rx_byte <= 8'h00;
         flags <= '0;
         frame_length <= '0;
      end else begin
         hist <= next_hist;
         rx_state <= next_rx_state;
         bit_cnt <= next_bit_cnt;
         exit_cnt <= next_exit_cnt;
         deser <= next_deser;
         crc <= next_crc;
         crc_on <= next_crc_on;
         octet_cnt <= next_octet_cnt;
         fbuf <= next_fbuf;
         sil_cnt <= next_sil_cnt;
         act_cnt <= next_act_cnt;
         valid_seen <= next_valid_seen;
         end_delim_detect <= next_end_delim_detect;
         events <= next_events;
         rx_byte <= next_rx_byte;
         flags <= next_flags;
         frame_length <= next_frame_length;
      end
   end

   // octet 0 (frame control) sits in the low byte
   for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_buf
      assign frame_buffer[i*8 +: 8] = fbuf[i];
   end

endmodule // sqf_receive_framer

// >>> sqf_receive_framer_properties.sv
`timescale 1ns/1ps
module sqf_receive_framer_properties #(
   parameter int ADDR_OCTETS = 6,
   parameter int MAX_OCTETS = 8191,
   parameter int BUF_DEPTH = 32
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic recovered_symbol_clock,
   input wire logic [2:0] line_symbol,
   input wire logic clr_protocol_frame,
   input wire logic clr_data_frame,
   input wire logic clr_noise_burst,
   input wire logic end_delim_detect,
   input wire sqf_pkg::sqf_event_s events,
   input wire logic [7:0] rx_byte,
   input wire sqf_pkg::sqf_flags_s flags,
   input wire logic [$clog2(MAX_OCTETS+2)-1:0] frame_length,
   input wire logic [BUF_DEPTH*8-1:0] frame_buffer
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   localparam int MIN_LEN = 1 + 2 * ADDR_OCTETS + 4;
   a_ed_returned: assert property (events.ed |-> end_delim_detect)
      else $error("frame end without delimiter pulse");
   a_quiet_after_flag: assert property (
      $rose(flags.rx_protocol_frame) || $rose(flags.rx_data_frame) |-> !flags.bus_quiet)
      else $error("bus quiet ahead of frame flag");
   a_flag_on_end: assert property ($rose(flags.rx_protocol_frame) |-> events.ed)
      else $error("control flag without frame end");
   a_legal_length: assert property (
      $rose(flags.rx_data_frame) |-> events.ed && frame_length >= MIN_LEN)
      else $error("data flag on short frame");
   a_ed_no_err: assert property (events.ed |-> !events.err)
      else $error("error on normal frame end");
   a_noise_on_quiet: assert property ($rose(flags.noise_burst) |-> $rose(flags.bus_quiet))
      else $error("noise burst off quiet edge");
   a_strobe_gap: assert property (events.byte_strobe |=> !events.byte_strobe [*8])
      else $error("byte strobes too close");
   a_proto_clear: assert property (
      clr_protocol_frame |=> !flags.rx_protocol_frame || events.ed)
      else $error("control flag not cleared");
   a_data_clear: assert property (clr_data_frame |=> !flags.rx_data_frame || events.ed)
      else $error("data flag not cleared");
   a_noise_clear: assert property (
      clr_noise_burst |=> !flags.noise_burst || $rose(flags.bus_quiet))
      else $error("noise flag not cleared");
   cover property ($rose(flags.rx_protocol_frame));
   cover property ($rose(flags.rx_data_frame));
   cover property ($rose(flags.noise_burst));
   cover property (events.sd && events.err);
endmodule // sqf_receive_framer_properties

bind sqf_receive_framer sqf_receive_framer_properties #(.ADDR_OCTETS(ADDR_OCTETS),
   .MAX_OCTETS(MAX_OCTETS), .BUF_DEPTH(BUF_DEPTH)) u_props (.clock(clock),
   .reset_n(reset_n), .recovered_symbol_clock(recovered_symbol_clock),
   .line_symbol(line_symbol), .clr_protocol_frame(clr_protocol_frame),
   .clr_data_frame(clr_data_frame), .clr_noise_burst(clr_noise_burst),
   .end_delim_detect(end_delim_detect), .events(events), .rx_byte(rx_byte),
   .flags(flags), .frame_length(frame_length), .frame_buffer(frame_buffer));

// >>> sqf_receive_framer_tb_top.sv
`timescale 1ns/1ps
module sqf_receive_framer_tb_top;
   logic clock;
   logic reset_n;
   logic [2:0] clr;
   logic rsc;
   logic [2:0] sym_in;
   logic end_delim_detect;
   sqf_pkg::sqf_event_s events;
   logic [7:0] rx_byte;
   sqf_pkg::sqf_flags_s flags;
   logic [13:0] frame_length;
   logic [255:0] frame_buffer;
   logic [4:0] ev;
   logic [7:0] cnt [5];
   logic [7:0] base [5];
   logic [7:0] last [9];
   int num_errors = 0;
   int tests_run = 0;
   sqf_phy_model u_phy (.recovered_symbol_clock(rsc), .line_symbol(sym_in));
   // two-octet addresses keep frames short
   sqf_receive_framer #(.ADDR_OCTETS(2)) u_dut (.clock(clock), .reset_n(reset_n),
      .recovered_symbol_clock(rsc), .line_symbol(sym_in), .clr_protocol_frame(clr[0]),
      .clr_data_frame(clr[1]), .clr_noise_burst(clr[2]), .end_delim_detect(end_delim_detect),
      .events(events), .rx_byte(rx_byte), .flags(flags), .frame_length(frame_length),
      .frame_buffer(frame_buffer));
   assign ev = {events.sd, events.ed, events.byte_strobe, events.err, end_delim_detect};
   always_ff @(posedge clock)
      for (int i = 0; i < 5; i++) cnt[i] <= !reset_n ? 8'h00 : cnt[i] + 8'(ev[i] === 1'b1);
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
      for (int i = 7; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? sqf_pkg::CRC_POLY : 0);
      return c;
   endfunction
   task automatic sym(input logic [2:0] s);
      u_phy.send(s);
   endtask
   task automatic octet(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) sym(3'(b[i]));
   endtask
   // start delimiter with b1 zero, end delimiter with b1 one
   task automatic delim(input logic [2:0] b1);
      for (int i = 0; i < 8; i++)
         sym((i == 2 || i == 5) ? b1 : (i > 5) ? sqf_pkg::SYM_ZERO : sqf_pkg::SYM_NON_DATA);
   endtask
   task automatic settle();
      u_phy.rest();
      repeat (16) @(posedge clock);
   endtask
   task automatic sil();
      repeat (10) sym(sqf_pkg::SYM_SILENCE);
      settle();
   endtask
   task automatic mark();
      base = cnt;
   endtask
   task automatic evs(input logic [7:0] sd, ed, by, er, dd);
      chk(cnt[4] - base[4], sd);
      chk(cnt[3] - base[3], ed);
      chk(cnt[2] - base[2], by);
      chk(cnt[1] - base[1], er);
      chk(cnt[0] - base[0], dd);
   endtask
   task automatic pulse(input int k);
      @(posedge clock) clr <= 3'h1 << k;
      @(posedge clock) clr <= 3'h0;
      repeat (2) @(posedge clock);
   endtask
   task automatic frame(input logic [7:0] fc, input logic bad);
      logic [31:0] c;
      c = sqf_pkg::CRC_INIT;
      last[0] = fc;
      for (int i = 1; i < 5; i++) last[i] = 8'(i * 17);
      for (int i = 0; i < 5; i++) c = crc_step(c, last[i]);
      c = ~c ^ {31'h0, bad};
      for (int i = 0; i < 4; i++) last[5 + i] = c[31 - 8 * i -: 8];
      mark();
      delim(sqf_pkg::SYM_ZERO);
      for (int i = 0; i < 9; i++) octet(last[i]);
      delim(sqf_pkg::SYM_ONE);
      settle();
      evs(1, 1, 9, 0, 1);
   endtask
   task automatic t_ctrl();
      frame(8'h01, 1'b0);
      chk(flags.rx_protocol_frame, 1);
      chk(frame_length, 9);
      for (int i = 0; i < 9; i++) chk(frame_buffer[i*8+:8], last[i]);
      chk(rx_byte, last[8]);
      sil();
      chk({flags.bus_quiet, flags.noise_burst}, 2'h2);
      pulse(0);
      chk(flags.rx_protocol_frame, 0);
   endtask
   task automatic t_data();
      frame(8'h40, 1'b0);
      chk({flags.bus_quiet, flags.rx_data_frame}, 2'h1);
      pulse(1);
      chk(flags.rx_data_frame, 0);
   endtask
   task automatic t_bad_fcs();
      // quiet must fall during the bad frame, else the earlier good frame still counts
      sil();
      frame(8'h01, 1'b1);
      chk(flags.rx_protocol_frame, 0);
      sil();
      chk(flags.noise_burst, 1);
      pulse(2);
      chk(flags.noise_burst, 0);
   endtask
   // k 0: non-data off boundary, k 1: stray boundary non-data, then pad, silence, bad
   task automatic t_exits();
      for (int k = 0; k < 5; k++) begin
         mark();
         delim(sqf_pkg::SYM_ZERO);
         octet(8'ha5);
         repeat (k == 0 ? 3 : 0) sym(sqf_pkg::SYM_ZERO);
         sym(3'(k < 2 ? 2 : k + 1));
         repeat (7) sym(sqf_pkg::SYM_ZERO);
         delim(sqf_pkg::SYM_ONE);
         settle();
         evs(1, 0, 1, 1, 1);
      end
   endtask
   task automatic t_resync();
      mark();
      delim(sqf_pkg::SYM_ZERO);
      octet(8'ha5);
      delim(sqf_pkg::SYM_ZERO);
      octet(8'h5a);
      delim(sqf_pkg::SYM_ONE);
      settle();
      evs(2, 1, 2, 1, 1);
      chk(flags.rx_data_frame, 0);
   endtask
   initial begin
      reset_n = 1'b0;
      clr = 3'h0;
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      repeat (8) @(posedge clock);
      chk({events, end_delim_detect, flags}, 0);
      t_ctrl();
      t_data();
      t_bad_fcs();
      t_exits();
      t_resync();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      close_out();
   end
endmodule // sqf_receive_framer_tb_top
